// File: common/ssc_pkg.sv
// Constants and types for the serial slave read and coil force block
// Summary of operation
// - At most 125 registers per read
// - Read reply: address, 04h, byte count 2n, data, CRC
// - Bad register address: exception 02h, count it
// - Bad register count: exception 03h, count it
// - Malformed read: exception 03h, count it
// - Function 05h sets or clears one coil
// - Successful force reply echoes the request
// - Physical coils 0-26 reset themselves
// - Forced physical coil pulses its contact one second
// - Pulsed remote bits 59-90 clear at end
// - Coil 27 is the first remote bit
package ssc_pkg;
  localparam logic [7:0] FUNC_READ_INPUT = 8'h04;
  localparam logic [7:0] FUNC_FORCE_COIL = 8'h05;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
  localparam logic [7:0] COIL_OP_SET = 8'hff;
  localparam logic [7:0] COIL_OP_CLEAR = 8'h00;
  localparam logic [7:0] COIL_PLACEHOLDER = 8'h00;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [15:0] MAX_READ_REGS = 16'h007d;
  localparam logic [3:0] REQ_LEN = 4'h8;
  localparam logic [3:0] MIN_LEN = 4'h4;
  localparam logic [3:0] RX_BUF_DEPTH = 4'h8;
  localparam logic [7:0] EXC_BODY_LEN = 8'h03;
  localparam logic [7:0] ECHO_BODY_LEN = 8'h06;
  localparam logic [7:0] READ_HDR_LEN = 8'h03;
  localparam logic [15:0] COIL_PHYS_LAST = 16'h001a;
  localparam logic [15:0] COIL_RB_FIRST = 16'h001b;
  localparam logic [15:0] COIL_RB_LAST = 16'h003a;
  localparam logic [15:0] COIL_RB_PULSE_FIRST = 16'h003b;
  localparam logic [15:0] COIL_RB_PULSE_LAST = 16'h005a;
  localparam int NUM_CONTACTS = 15;
  localparam int NUM_REMOTE = 32;
  localparam int NUM_CHAN = NUM_CONTACTS + NUM_REMOTE;
  localparam logic [5:0] CHAN_NONE = 6'h3f;
  localparam int CNT_W = 26;
  localparam int CLK_HZ = 50000000;
  localparam int PULSE_TIME_MS = 1000;
  localparam logic [CNT_W-1:0] PULSE_CYCLES_DEF =
    CNT_W'(CLK_HZ / 1000 * PULSE_TIME_MS);
  localparam int CTR_W = 16;

  typedef enum logic [2:0] {
    SSC_IDLE, SSC_CHECK, SSC_SCAN, SSC_ADDR, SSC_LOAD, SSC_WAIT
  } ssc_state_t;

  typedef enum logic [1:0] {
    SSC_RESP_EXC, SSC_RESP_READ, SSC_RESP_ECHO
  } ssc_resp_t;
endpackage

// File: common/ssc_pulse_if.sv
// Start, cancel and status lines between the command engine and timers
`timescale 1ns/1ps
`default_nettype none
interface ssc_pulse_if;
  import ssc_pkg::*;
  logic [NUM_CHAN-1:0] start;
  logic [NUM_CHAN-1:0] cancel;
  logic [NUM_CHAN-1:0] active;
  logic [NUM_CHAN-1:0] done;
  modport ctrl (output start, output cancel, input active, input done);
  modport bank (input start, input cancel, output active, output done);
endinterface
`default_nettype wire

// File: hdl/ssc_pulse_bank.sv
// One-shot pulse timers, one per contact or pulsed remote bit
`timescale 1ns/1ps
`default_nettype none
module ssc_pulse_bank
  import ssc_pkg::*;
#(
  parameter logic [CNT_W-1:0] PULSE_CYCLES = PULSE_CYCLES_DEF
)
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  ssc_pulse_if.bank pulse
);
  for (genvar g = 0; g < NUM_CHAN; g++)
  begin : g_chan
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic act;
    logic next_act;
    logic dn;
    logic next_dn;

    always_comb
    begin
      next_cnt = cnt;
      next_act = act;
      next_dn = 1'b0;
      if (pulse.start[g])
      begin
        // A new force reloads the full period
        next_cnt = PULSE_CYCLES;
        next_act = 1'b1;
      end
      else if (pulse.cancel[g])
      begin
        next_cnt = '0;
        next_act = 1'b0;
      end
      else if (act)
      begin
        if (cnt == CNT_W'(1))
        begin
          next_cnt = '0;
          next_act = 1'b0;
          next_dn = 1'b1;
        end
        else
        begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
    end

    always_ff @(posedge core_clk_i)
    begin
      if (reset_i)
      begin
        cnt <= '0;
        act <= 1'b0;
        dn <= 1'b0;
      end
      else
      begin
        cnt <= next_cnt;
        act <= next_act;
        dn <= next_dn;
      end
    end

    assign pulse.active[g] = act;
    assign pulse.done[g] = dn;
  end
endmodule
`default_nettype wire

// File: hdl/ssc_slave_top.sv
// Slave command engine for input register reads and single coil forces
`timescale 1ns/1ps
`default_nettype none
module ssc_slave_top
  import ssc_pkg::*;
#(
  parameter logic [CNT_W-1:0] PULSE_CYCLES = PULSE_CYCLES_DEF
)
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] slave_addr_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_frame_end_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output logic [15:0] reg_addr_o,
  input wire logic [15:0] reg_data_i,
  input wire logic reg_bad_i,
  output logic [CTR_W-1:0] invalid_addr_count_o,
  output logic [CTR_W-1:0] illegal_reg_count_o,
  output logic [CTR_W-1:0] bad_format_count_o,
  output logic slot1_contact_a_o,
  output logic slot1_contact_b_o,
  output logic slot1_contact_c_o,
  output logic slot3_contact_a_o,
  output logic slot3_contact_b_o,
  output logic slot3_contact_c_o,
  output logic slot3_contact_d_o,
  output logic slot4_contact_a_o,
  output logic slot4_contact_b_o,
  output logic slot4_contact_c_o,
  output logic slot4_contact_d_o,
  output logic slot5_contact_a_o,
  output logic slot5_contact_b_o,
  output logic slot5_contact_c_o,
  output logic slot5_contact_d_o,
  output logic [NUM_REMOTE-1:0] remote_control_bits_o
);
  ssc_pulse_if pulse ();

  ssc_pulse_bank #(.PULSE_CYCLES(PULSE_CYCLES)) u_bank (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .pulse(pulse.bank)
  );

  ssc_state_t state, next_state;
  ssc_resp_t resp, next_resp;
  logic [7:0] rx_buf [RX_BUF_DEPTH];
  logic [7:0] next_rx_buf [RX_BUF_DEPTH];
  logic [3:0] rx_len, next_rx_len;
  logic [15:0] crc_rx, next_crc_rx;
  logic [15:0] crc_tx, next_crc_tx;
  logic [7:0] exc_code, next_exc_code;
  logic [7:0] byte_idx, next_byte_idx;
  logic [7:0] body_len, next_body_len;
  logic [15:0] scan_idx, next_scan_idx;
  logic [15:0] next_reg_addr;
  logic [7:0] next_tx_data;
  logic next_tx_valid, next_tx_last;
  logic [CTR_W-1:0] next_invalid, next_illegal, next_badfmt;
  logic [NUM_REMOTE-1:0] next_rb;
  logic [NUM_CHAN-1:0] start_q, next_start, cancel_q, next_cancel;

  logic [7:0] func;
  logic [15:0] field_a;
  logic [15:0] field_b;
  logic [7:0] data_idx;
  logic [7:0] body_byte;
  logic [5:0] chan;
  logic [4:0] rb_idx;

  assign func = rx_buf[1];
  assign field_a = {rx_buf[2], rx_buf[3]};
  assign field_b = {rx_buf[4], rx_buf[5]};
  assign data_idx = byte_idx - READ_HDR_LEN;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Physical coil to timer channel; gaps are reserved coils
  function automatic logic [5:0] coil_chan(input logic [4:0] c);
    if (c <= 5'h06)
      return {1'b0, c};
    else if (c >= 5'h0b && c <= 5'h0e)
      return {1'b0, c - 5'h04};
    else if (c >= 5'h13 && c <= 5'h16)
      return {1'b0, c - 5'h08};
    else
      return CHAN_NONE;
  endfunction

  assign chan = coil_chan(field_a[4:0]);

  always_comb
  begin
    body_byte = 8'h00;
    unique case (resp)
      SSC_RESP_EXC:
        body_byte = (byte_idx == 8'h00) ? slave_addr_i :
                    (byte_idx == 8'h01) ? (func | EXC_FLAG) : exc_code;
      SSC_RESP_ECHO:
        body_byte = rx_buf[byte_idx[2:0]];
      SSC_RESP_READ:
        if (byte_idx == 8'h00)
          body_byte = slave_addr_i;
        else if (byte_idx == 8'h01)
          body_byte = FUNC_READ_INPUT;
        else if (byte_idx == 8'h02)
          body_byte = {field_b[6:0], 1'b0};
        else
          body_byte = data_idx[0] ? reg_data_i[7:0] : reg_data_i[15:8];
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_resp = resp;
    next_rx_buf = rx_buf;
    next_rx_len = rx_len;
    next_crc_rx = crc_rx;
    next_crc_tx = crc_tx;
    next_exc_code = exc_code;
    next_byte_idx = byte_idx;
    next_body_len = body_len;
    next_scan_idx = scan_idx;
    next_reg_addr = reg_addr_o;
    next_tx_data = tx_data_o;
    next_tx_valid = tx_valid_o;
    next_tx_last = tx_last_o;
    next_invalid = invalid_addr_count_o;
    next_illegal = illegal_reg_count_o;
    next_badfmt = bad_format_count_o;
    next_start = '0;
    next_cancel = '0;
    rb_idx = 5'h00;
    // A pulsed remote bit clears when its pulse ends
    next_rb = remote_control_bits_o & ~pulse.done[NUM_CHAN-1:NUM_CONTACTS];
    unique case (state)
      SSC_IDLE:
      begin
        if (rx_valid_i)
        begin
          if (rx_len < RX_BUF_DEPTH)
            next_rx_buf[rx_len[2:0]] = rx_data_i;
          if (rx_len != 4'hf)
            next_rx_len = rx_len + 4'h1;
          next_crc_rx = crc_step(crc_rx, rx_data_i);
        end
        if (rx_frame_end_i)
          next_state = SSC_CHECK;
      end
      SSC_CHECK:
      begin
        next_rx_len = 4'h0;
        next_crc_rx = CRC_INIT;
        next_state = SSC_IDLE;
        next_resp = SSC_RESP_EXC;
        next_body_len = EXC_BODY_LEN;
        next_byte_idx = 8'h00;
        next_crc_tx = CRC_INIT;
        if (crc_rx == CRC_RESIDUE && rx_len >= MIN_LEN &&
            rx_buf[0] == slave_addr_i)
        begin
          next_state = SSC_ADDR;
          next_exc_code = EXC_BAD_VALUE;
          if (func == FUNC_READ_INPUT)
          begin
            if (rx_len != REQ_LEN)
              next_badfmt = bad_format_count_o + CTR_W'(1);
            else if (field_b == 16'h0000 || field_b > MAX_READ_REGS)
              next_illegal = illegal_reg_count_o + CTR_W'(1);
            else
            begin
              // Raw field is the native address; no 3X offset is subtracted
              next_reg_addr = field_a;
              next_scan_idx = 16'h0000;
              next_state = SSC_SCAN;
            end
          end
          else if (func == FUNC_FORCE_COIL)
          begin
            if (rx_len != REQ_LEN ||
                (rx_buf[4] != COIL_OP_SET && rx_buf[4] != COIL_OP_CLEAR) ||
                rx_buf[5] != COIL_PLACEHOLDER)
              next_badfmt = bad_format_count_o + CTR_W'(1);
            else if (field_a > COIL_RB_PULSE_LAST)
            begin
              next_exc_code = EXC_BAD_ADDR;
              next_invalid = invalid_addr_count_o + CTR_W'(1);
            end
            else
            begin
              next_resp = SSC_RESP_ECHO;
              next_body_len = ECHO_BODY_LEN;
              if (field_a <= COIL_PHYS_LAST)
              begin
                // Reserved coils map to no channel and do nothing
                if (chan != CHAN_NONE)
                begin
                  next_start[chan] = (rx_buf[4] == COIL_OP_SET);
                  next_cancel[chan] = (rx_buf[4] == COIL_OP_CLEAR);
                end
              end
              else if (field_a <= COIL_RB_LAST)
              begin
                rb_idx = 5'(field_a - COIL_RB_FIRST);
                next_rb[rb_idx] = (rx_buf[4] == COIL_OP_SET);
              end
              else
              begin
                rb_idx = 5'(field_a - COIL_RB_PULSE_FIRST);
                next_rb[rb_idx] = (rx_buf[4] == COIL_OP_SET);
                next_start[NUM_CONTACTS + int'(rb_idx)] =
                  (rx_buf[4] == COIL_OP_SET);
                next_cancel[NUM_CONTACTS + int'(rb_idx)] =
                  (rx_buf[4] == COIL_OP_CLEAR);
              end
            end
          end
          else
            next_exc_code = EXC_ILLEGAL_FUNC;
        end
      end
      SSC_SCAN:
      begin
        if (reg_bad_i)
        begin
          next_exc_code = EXC_BAD_ADDR;
          next_invalid = invalid_addr_count_o + CTR_W'(1);
          next_state = SSC_ADDR;
        end
        else if (scan_idx == field_b - 16'h0001)
        begin
          next_resp = SSC_RESP_READ;
          next_body_len = READ_HDR_LEN + {field_b[6:0], 1'b0};
          next_state = SSC_ADDR;
        end
        else
        begin
          next_scan_idx = scan_idx + 16'h0001;
          next_reg_addr = reg_addr_o + 16'h0001;
        end
      end
      SSC_ADDR:
      begin
        next_reg_addr = field_a + {9'h000, data_idx[7:1]};
        next_state = SSC_LOAD;
      end
      SSC_LOAD:
      begin
        next_tx_valid = 1'b1;
        if (byte_idx < body_len)
        begin
          next_tx_data = body_byte;
          next_crc_tx = crc_step(crc_tx, body_byte);
        end
        else if (byte_idx == body_len)
          next_tx_data = crc_tx[7:0];
        else
        begin
          next_tx_data = crc_tx[15:8];
          next_tx_last = 1'b1;
        end
        next_state = SSC_WAIT;
      end
      SSC_WAIT:
      begin
        if (tx_ready_i)
        begin
          next_tx_valid = 1'b0;
          next_tx_last = 1'b0;
          next_byte_idx = byte_idx + 8'h01;
          next_state = tx_last_o ? SSC_IDLE : SSC_ADDR;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state <= SSC_IDLE;
      resp <= SSC_RESP_EXC;
      for (int i = 0; i < RX_BUF_DEPTH; i++)
        rx_buf[i] <= 8'h00;
      rx_len <= 4'h0;
      crc_rx <= CRC_INIT;
      crc_tx <= CRC_INIT;
      exc_code <= 8'h00;
      byte_idx <= 8'h00;
      body_len <= 8'h00;
      scan_idx <= 16'h0000;
      reg_addr_o <= 16'h0000;
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
      invalid_addr_count_o <= '0;
      illegal_reg_count_o <= '0;
      bad_format_count_o <= '0;
      remote_control_bits_o <= '0;
      start_q <= '0;
      cancel_q <= '0;
    end
    else
    begin
      state <= next_state;
      resp <= next_resp;
      rx_buf <= next_rx_buf;
      rx_len <= next_rx_len;
      crc_rx <= next_crc_rx;
      crc_tx <= next_crc_tx;
      exc_code <= next_exc_code;
      byte_idx <= next_byte_idx;
      body_len <= next_body_len;
      scan_idx <= next_scan_idx;
      reg_addr_o <= next_reg_addr;
      tx_data_o <= next_tx_data;
      tx_valid_o <= next_tx_valid;
      tx_last_o <= next_tx_last;
      invalid_addr_count_o <= next_invalid;
      illegal_reg_count_o <= next_illegal;
      bad_format_count_o <= next_badfmt;
      remote_control_bits_o <= next_rb;
      start_q <= next_start;
      cancel_q <= next_cancel;
    end
  end

  assign pulse.start = start_q;
  assign pulse.cancel = cancel_q;

  // Contacts come straight from the timer flops
  assign slot1_contact_a_o = pulse.active[0];
  assign slot1_contact_b_o = pulse.active[1];
  assign slot1_contact_c_o = pulse.active[2];
  assign slot3_contact_a_o = pulse.active[3];
  assign slot3_contact_b_o = pulse.active[4];
  assign slot3_contact_c_o = pulse.active[5];
  assign slot3_contact_d_o = pulse.active[6];
  assign slot4_contact_a_o = pulse.active[7];
  assign slot4_contact_b_o = pulse.active[8];
  assign slot4_contact_c_o = pulse.active[9];
  assign slot4_contact_d_o = pulse.active[10];
  assign slot5_contact_a_o = pulse.active[11];
  assign slot5_contact_b_o = pulse.active[12];
  assign slot5_contact_c_o = pulse.active[13];
  assign slot5_contact_d_o = pulse.active[14];
endmodule
`default_nettype wire

// File: verif/ssc_master_model.sv
// Serial master model: sends request frames, collects response bytes
`timescale 1ns/1ps
`default_nettype none
module ssc_master_model
  import ssc_pkg::*;
(
  input wire logic core_clk_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_frame_end_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic tx_ready_o
);
  initial
  begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_frame_end_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // Check bytes go low byte first
  task automatic add_crc(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      @(posedge core_clk_i);
      rx_data_o <= q[i];
      rx_valid_o <= 1'b1;
    end
    @(posedge core_clk_i);
    rx_data_o <= ~rx_data_o;
    rx_valid_o <= 1'b0;
    rx_frame_end_o <= 1'b1;
    @(posedge core_clk_i);
    rx_frame_end_o <= 1'b0;
  endtask
  task automatic recv(input int stall, output logic [7:0] q[$],
                      output bit to);
    int w;
    bit fin;
    q = {};
    to = 1'b0;
    fin = 1'b0;
    while (!fin && !to)
    begin
      w = 0;
      @(negedge core_clk_i);
      while (tx_valid_i !== 1'b1 && w < 400)
      begin
        @(negedge core_clk_i);
        w++;
      end
      to = (tx_valid_i !== 1'b1);
      if (!to)
      begin
        repeat (stall) @(negedge core_clk_i);
        q.push_back(tx_data_i);
        fin = (tx_last_i === 1'b1);
        @(posedge core_clk_i);
        tx_ready_o <= 1'b1;
        @(posedge core_clk_i);
        tx_ready_o <= 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: verif/ssc_monitor.sv
// Port checks for the slave command engine
`timescale 1ns/1ps
`default_nettype none
module ssc_monitor
  import ssc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] slave_addr_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic [CTR_W-1:0] invalid_addr_count_o,
  input wire logic [CTR_W-1:0] illegal_reg_count_o,
  input wire logic [CTR_W-1:0] bad_format_count_o,
  input wire logic slot1_contact_a_o,
  input wire logic [NUM_REMOTE-1:0] remote_control_bits_o
);
  logic first;
  logic next_first;
  logic acc;
  assign acc = tx_valid_o & tx_ready_i;
  // Marks the first byte of each response
  always_comb
  begin
    next_first = acc ? tx_last_o : first;
  end
  always_ff @(posedge core_clk_i)
  begin
    first <= reset_i ? 1'b1 : next_first;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  tx_hold_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte changed before accept");
  tx_gap_a: assert property (
    acc && !tx_last_o |=> !tx_valid_o ##[1:2] tx_valid_o)
    else $error("next tx byte late");
  tx_end_a: assert property (
    acc && tx_last_o |=> !tx_valid_o [*3])
    else $error("tx continued after last");
  tx_addr_a: assert property (
    tx_valid_o && first |-> tx_data_o == slave_addr_i)
    else $error("response not led by slave address");
  reset_quiet_a: assert property (
    $fell(reset_i) |-> !tx_valid_o && !slot1_contact_a_o &&
    remote_control_bits_o == '0 && invalid_addr_count_o == '0)
    else $error("outputs active after reset");
  addr_count_a: assert property (
    $changed(invalid_addr_count_o) |-> $stable(bad_format_count_o) &&
    invalid_addr_count_o == CTR_W'($past(invalid_addr_count_o) + 1))
    else $error("invalid address count step wrong");
  reg_count_a: assert property (
    $changed(illegal_reg_count_o) |-> $stable(invalid_addr_count_o) &&
    illegal_reg_count_o == CTR_W'($past(illegal_reg_count_o) + 1))
    else $error("illegal register count step wrong");
  format_count_a: assert property (
    $changed(bad_format_count_o) |-> $stable(illegal_reg_count_o) &&
    bad_format_count_o == CTR_W'($past(bad_format_count_o) + 1))
    else $error("bad format count step wrong");
  pulse_min_a: assert property (
    $rose(slot1_contact_a_o) |-> slot1_contact_a_o [*8])
    else $error("contact pulse too short");
  pulse_cause_a: assert property (
    $rose(slot1_contact_a_o) |-> ##[0:4] tx_valid_o)
    else $error("contact rose without a force");
  remote_cause_a: assert property (
    $rose(remote_control_bits_o[0]) |-> ##[0:4] tx_valid_o)
    else $error("remote bit rose without a force");
endmodule
bind ssc_slave_top ssc_monitor ssc_monitor_i (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .slave_addr_i(slave_addr_i), .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
  .invalid_addr_count_o(invalid_addr_count_o),
  .illegal_reg_count_o(illegal_reg_count_o),
  .bad_format_count_o(bad_format_count_o),
  .slot1_contact_a_o(slot1_contact_a_o),
  .remote_control_bits_o(remote_control_bits_o));
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the slave command engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ssc_pkg::*;
  localparam logic [CNT_W-1:0] PULSE = 26'h3c;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] slv = 8'h11;
  wire logic [7:0] rxd, txd;
  wire logic rxv, rxe, txv, txl, txr, rbad;
  wire logic [15:0] radr, rdat;
  wire logic [CTR_W-1:0] c_addr, c_reg, c_fmt;
  wire logic [14:0] cont;
  wire logic [NUM_REMOTE-1:0] rbits;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  // Register map: addresses above 00ffh are not readable
  assign rbad = radr[15:8] != 8'h00;
  assign rdat = {radr[7:0], ~radr[7:0]};
  ssc_slave_top #(.PULSE_CYCLES(PULSE)) ssc_slave_top_i (
    .core_clk_i(clk), .reset_i(rst), .slave_addr_i(slv), .rx_data_i(rxd),
    .rx_valid_i(rxv), .rx_frame_end_i(rxe), .tx_data_o(txd), .tx_valid_o(txv),
    .tx_last_o(txl), .tx_ready_i(txr), .reg_addr_o(radr), .reg_data_i(rdat),
    .reg_bad_i(rbad), .invalid_addr_count_o(c_addr),
    .illegal_reg_count_o(c_reg), .bad_format_count_o(c_fmt),
    .slot1_contact_a_o(cont[0]), .slot1_contact_b_o(cont[1]),
    .slot1_contact_c_o(cont[2]), .slot3_contact_a_o(cont[3]),
    .slot3_contact_b_o(cont[4]), .slot3_contact_c_o(cont[5]),
    .slot3_contact_d_o(cont[6]), .slot4_contact_a_o(cont[7]),
    .slot4_contact_b_o(cont[8]), .slot4_contact_c_o(cont[9]),
    .slot4_contact_d_o(cont[10]), .slot5_contact_a_o(cont[11]),
    .slot5_contact_b_o(cont[12]), .slot5_contact_c_o(cont[13]),
    .slot5_contact_d_o(cont[14]), .remote_control_bits_o(rbits));
  ssc_master_model ssc_master_model_i (.core_clk_i(clk), .rx_data_o(rxd),
    .rx_valid_o(rxv), .rx_frame_end_o(rxe), .tx_data_i(txd),
    .tx_valid_i(txv), .tx_last_i(txl), .tx_ready_o(txr));
  task automatic results;
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_q(input logic [7:0] got[$], input logic [7:0] exp[$]);
    chk(got.size(), exp.size());
    foreach (exp[i])
      if (i < got.size()) chk(got[i], exp[i]);
  endtask
  task automatic xfer(input logic [7:0] f[$], input int stall, input bit bad,
                      output logic [7:0] r[$], output bit to);
    ssc_master_model_i.add_crc(f);
    if (bad) f[f.size() - 1] = f[f.size() - 1] ^ 8'h01;
    ssc_master_model_i.send(f);
    ssc_master_model_i.recv(stall, r, to);
  endtask
  task automatic t_read(input logic [15:0] st, input logic [7:0] n);
    logic [7:0] f[$], e[$], r[$];
    logic [15:0] a;
    bit to;
    f = '{8'h11, FUNC_READ_INPUT, st[15:8], st[7:0], 8'h00, n};
    e = '{8'h11, FUNC_READ_INPUT, 8'(2 * n)};
    for (int k = 0; k < n; k++)
    begin
      a = st + 16'(k);
      e.push_back(a[7:0]);
      e.push_back(~a[7:0]);
    end
    ssc_master_model_i.add_crc(e);
    xfer(f, 2, 1'b0, r, to);
    chk_q(r, e);
  endtask
  task automatic t_errs;
    logic [7:0] f[$], e[$], r[$];
    logic [CTR_W-1:0] a0, g0, b0;
    bit to;
    for (int k = 0; k < 7; k++)
    begin
      a0 = c_addr;
      g0 = c_reg;
      b0 = c_fmt;
      f = '{8'h11, FUNC_READ_INPUT, 8'h00, 8'h00, 8'h00, 8'h7e};
      if (k == 0) f[3] = 8'hfe;
      if (k == 0) f[5] = 8'h03;
      if (k == 2 || k == 6) f[5] = 8'h00;
      if (k == 3) f[5] = 8'h01;
      if (k == 3) f.push_back(8'h00);
      // Unknown function, bad force operation, force coil past the table
      if (k > 3) f[1] = (k == 4) ? 8'h03 : FUNC_FORCE_COIL;
      if (k == 5) f[4] = 8'h12;
      if (k == 6) f[3] = 8'h5b;
      e = '{8'h11, f[1] | EXC_FLAG, EXC_BAD_VALUE};
      if (k == 0 || k == 6) e[2] = EXC_BAD_ADDR;
      if (k == 4) e[2] = EXC_ILLEGAL_FUNC;
      ssc_master_model_i.add_crc(e);
      xfer(f, 0, 1'b0, r, to);
      chk_q(r, e);
      chk(c_addr, a0 + 16'(k == 0 || k == 6));
      chk(c_reg, g0 + 16'(k == 1 || k == 2));
      chk(c_fmt, b0 + 16'(k == 3 || k == 5));
    end
  endtask
  task automatic t_force(input logic [15:0] c, input logic [7:0] op);
    logic [7:0] f[$], e[$], r[$];
    bit to;
    f = '{8'h11, FUNC_FORCE_COIL, c[15:8], c[7:0], op, COIL_PLACEHOLDER};
    e = f;
    ssc_master_model_i.add_crc(e);
    xfer(f, 0, 1'b0, r, to);
    chk_q(r, e);
    @(negedge clk);
  endtask
  task automatic t_phys;
    for (int i = 0; i < 15; i++)
    begin
      t_force(16'(i < 7 ? i : (i < 11 ? i + 4 : i + 8)), COIL_OP_SET);
      chk(cont, 32'h1 << i);
      repeat (PULSE) @(posedge clk);
      chk(cont, 32'h0);
    end
  endtask
  task automatic t_restart;
    t_force(16'h1, COIL_OP_SET);
    // Second force lands while the first pulse still runs
    repeat (4) @(posedge clk);
    t_force(16'h1, COIL_OP_SET);
    repeat (10) @(posedge clk);
    chk(cont, 32'h2);
    t_force(16'h1, COIL_OP_CLEAR);
    chk(cont, 32'h0);
  endtask
  task automatic t_reserved;
    for (int i = 0; i < 3; i++)
    begin
      t_force(16'h7 + 16'(8 * i), COIL_OP_SET);
      chk(cont, 32'h0);
      chk(rbits, 32'h0);
    end
  endtask
  task automatic t_remote;
    t_force(16'h1b, COIL_OP_SET);
    chk(rbits, 32'h1);
    t_force(16'h1b, COIL_OP_CLEAR);
    chk(rbits, 32'h0);
    t_force(16'h3b, COIL_OP_SET);
    chk(rbits, 32'h1);
    // The first pulse has ended by the time the second echo is in
    t_force(16'h5a, COIL_OP_SET);
    chk(rbits, 32'h80000000);
    repeat (PULSE) @(posedge clk);
    chk(rbits, 32'h0);
  endtask
  task automatic t_discard;
    logic [7:0] f[$], r[$];
    bit to;
    // A latched remote coil would stay set if a frame slipped through
    f = '{8'h11, FUNC_FORCE_COIL, 8'h00, 8'h1b, COIL_OP_SET, 8'h00};
    xfer(f, 0, 1'b1, r, to);
    chk(to, 32'h1);
    chk(rbits, 32'h0);
    f[0] = 8'h22;
    xfer(f, 0, 1'b0, r, to);
    chk(to, 32'h1);
    chk(cont, 32'h0);
    chk(rbits, 32'h0);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_read(16'h0010, 8'h01);
    t_read(16'h0000, 8'h7d);
    t_errs();
    t_phys();
    t_restart();
    t_reserved();
    t_remote();
    t_discard();
    results();
  end
endmodule
`default_nettype wire
